// *** shared/ccsf_pkg.sv ***
// Shared constants and types of the core execution slice.
`default_nettype none
package ccsf_pkg;

   // ****************************************************************
   // Data space map and status layout
   // ****************************************************************
   localparam logic [15:0] GPR_LAST        = 16'h001F;
   localparam logic [15:0] IO_DATA_BASE    = 16'h0020;
   localparam logic [15:0] IO_DATA_LAST    = 16'h005F;
   localparam logic [15:0] EXT_IO_LAST     = 16'h00FF;
   localparam logic [15:0] FLAGS_DATA_ADDR = 16'h005F;
   localparam logic [5:0]  FLAGS_IO_ADDR   = 6'h3F;
   localparam logic [7:0]  FLAGS_RESET     = 8'h00;
   localparam logic [15:0] RESET_VECTOR    = 16'h0000;
   localparam int          FL_I            = 7;
   localparam int          FL_T            = 6;
   localparam int          FL_H            = 5;
   localparam int          FL_S            = 4;
   localparam int          FL_V            = 3;
   localparam int          FL_N            = 2;
   localparam int          FL_Z            = 1;
   localparam int          FL_C            = 0;
   localparam logic [4:0]  PTR_X_LO        = 5'h1A;
   localparam logic [4:0]  PTR_Z_LO        = 5'h1E;
   localparam int          IRQ_LINES       = 16;
   localparam int          IRQ_IDX_W       = 4;
   localparam logic [1:0]  RG_GPR          = 2'h0;
   localparam logic [1:0]  RG_FLAGS        = 2'h1;
   localparam logic [1:0]  RG_BUS          = 2'h2;

   // ****************************************************************
   // Decoded operations and sequencer phases
   // ****************************************************************
   typedef enum logic [4:0] {
      OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADD_CARRY = 5'h02,
      OP_SUB = 5'h03, OP_AND = 5'h04, OP_OR = 5'h05, OP_XOR = 5'h06,
      OP_COPY = 5'h07, OP_LOAD_IMM = 5'h08, OP_BIT_STORE = 5'h09,
      OP_BIT_LOAD = 5'h0A, OP_IRQ_GATE_SET = 5'h0B,
      OP_IRQ_GATE_CLEAR = 5'h0C, OP_RETURN_FROM_IRQ = 5'h0D,
      OP_CALL = 5'h0E, OP_LOAD_DIRECT = 5'h0F, OP_STORE_DIRECT = 5'h10,
      OP_LOAD_PTR = 5'h11, OP_STORE_PTR = 5'h12, OP_IO_READ = 5'h13,
      OP_IO_WRITE = 5'h14, OP_TABLE_READ = 5'h15
   } ccsf_kind_t;

   typedef enum logic [3:0] {
      PH_RUN = 4'h0, PH_OPERAND = 4'h1, PH_LOAD1 = 4'h2, PH_LOAD2 = 4'h3,
      PH_PUSH2 = 4'h4, PH_POP1 = 4'h5, PH_POP2 = 4'h6, PH_POP3 = 4'h7,
      PH_TABLE1 = 4'h8, PH_TABLE2 = 4'h9
   } ccsf_phase_t;

   typedef struct packed {
      ccsf_kind_t  kind;
      logic [4:0]  rd;
      logic [4:0]  rr;
      logic [7:0]  imm;
      logic [2:0]  bsel;
      logic [1:0]  ptr;
   } ccsf_op_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } ccsf_dbus_t;

   typedef struct packed {
      ccsf_phase_t          phase;
      logic [31:0][7:0]     gpr;
      logic [7:0]           flags;
      logic [15:0]          program_counter;
      logic [15:0]          stack_top_pointer;
      logic                 fetch_ok;
      ccsf_op_t             held;
      logic [15:0]          target;
      logic [7:0]           spare;
      logic [15:0]          pm_addr;
      ccsf_dbus_t           dbus;
      logic [IRQ_LINES-1:0] irq_ack;
   } ccsf_state_t;

endpackage
`default_nettype wire

// *** design/ccsf_core.sv ***
// Execution slice: fetch overlap, register file, ALU, flags, interrupts.
`timescale 1ns/100ps
`default_nettype none

module ccsf_core #(
   parameter logic [15:0] STACK_RESET = 16'h00FF,
   parameter logic [15:0] VEC_WORDS   = 16'h0001
) (
   input  wire logic                           REF_CLK,   // Core clock
   input  wire logic                           NRST,      // Sync reset
   output logic [15:0]                         PM_ADDR,   // Fetch word addr
   input  wire logic [15:0]                    PM_WORD,   // Fetched word
   input  wire ccsf_pkg::ccsf_op_t             OP,        // Decoded word
   output logic [15:0]                         DM_ADDR,   // Data address
   output logic [7:0]                          DM_WDATA,  // Store data
   output logic                                DM_WE,     // Store strobe
   output logic                                DM_RE,     // Load strobe
   input  wire logic [7:0]                     DM_RDATA,  // Load data
   input  wire logic [ccsf_pkg::IRQ_LINES-1:0] IRQ_REQ,   // Pending sources
   output logic [ccsf_pkg::IRQ_LINES-1:0]      IRQ_ACK,   // Taken, one-hot
   output logic [7:0]                          FLAGS      // Status view
);
   import ccsf_pkg::*;

   ccsf_state_t           s;
   ccsf_state_t           n;
   ccsf_op_t              cur;
   logic [7:0]            rd_val;
   logic [7:0]            rr_val;
   logic [4:0]            ptr_idx;
   logic [15:0]           ptr_val;
   logic [15:0]           table_ptr;
   logic [15:0]           io_addr;
   logic [15:0]           alu_out;
   logic [IRQ_IDX_W-1:0]  irq_idx;
   logic [15:0]           vector;
   logic                  irq_hit;
   logic                  run_ok;
   logic                  take_irq;
   logic                  is_alu;
   logic                  acc_go;
   logic                  acc_wr;
   logic [15:0]           acc_addr;

   // ****************************************************************
   // Decoding helpers
   // ****************************************************************
   function automatic logic [IRQ_IDX_W-1:0] lowest_irq(
      input logic [IRQ_LINES-1:0] req);
      logic [IRQ_IDX_W-1:0] idx;
      idx = '0;
      for (int i = IRQ_LINES - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = IRQ_IDX_W'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [1:0] region_of(input logic [15:0] a);
      if (a <= GPR_LAST) begin
         return RG_GPR;
      end else if (a == FLAGS_DATA_ADDR) begin
         return RG_FLAGS;
      end
      return RG_BUS;
   endfunction

   // Returns result in the upper byte and the new flags in the lower.
   function automatic logic [15:0] alu_eval(input ccsf_kind_t k,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
      logic [8:0] sum;
      logic [4:0] nib;
      logic [7:0] r;
      logic [7:0] nf;
      logic       cin;
      cin = (k == OP_ADD_CARRY) & f[FL_C];
      sum = '0;
      nib = '0;
      r   = a;
      nf  = f;
      case (k)
         OP_ADD, OP_ADD_CARRY: begin
            sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            r = sum[7:0];
            nf[FL_C] = sum[8];
            nf[FL_H] = nib[4];
            nf[FL_V] = (a[7] == b[7]) && (r[7] != a[7]);
         end
         OP_SUB: begin
            sum = {1'b0, a} - {1'b0, b};
            nib = {1'b0, a[3:0]} - {1'b0, b[3:0]};
            r = sum[7:0];
            nf[FL_C] = sum[8];
            nf[FL_H] = nib[4];
            nf[FL_V] = (a[7] != b[7]) && (r[7] != a[7]);
         end
         OP_AND: begin
            r = a & b;
            nf[FL_V] = 1'b0;
         end
         OP_OR: begin
            r = a | b;
            nf[FL_V] = 1'b0;
         end
         OP_XOR: begin
            r = a ^ b;
            nf[FL_V] = 1'b0;
         end
         default: begin
            r = a;
         end
      endcase
      nf[FL_N] = r[7];
      nf[FL_Z] = (r == 8'h00);
      nf[FL_S] = nf[FL_N] ^ nf[FL_V];
      return {r, nf};
   endfunction

   // ****************************************************************
   // Operand paths
   // ****************************************************************
   assign cur       = (s.phase == PH_OPERAND) ? s.held : OP;
   assign rd_val    = s.gpr[cur.rd];
   assign rr_val    = s.gpr[cur.rr];
   assign ptr_idx   = (cur.ptr == 2'h3) ? PTR_Z_LO :
                      PTR_X_LO + {2'b00, cur.ptr, 1'b0};
   assign ptr_val   = {s.gpr[ptr_idx + 5'h01], s.gpr[ptr_idx]};
   assign table_ptr = {s.gpr[PTR_Z_LO + 5'h01], s.gpr[PTR_Z_LO]};
   // Six I/O address bits cannot reach past the I/O window.
   assign io_addr   = IO_DATA_BASE + {10'h000, cur.imm[5:0]};
   assign alu_out   = alu_eval(cur.kind, rd_val, rr_val, s.flags);
   assign is_alu    = cur.kind inside {OP_ADD, OP_ADD_CARRY, OP_SUB,
                                       OP_AND, OP_OR, OP_XOR};
   assign irq_idx   = lowest_irq(IRQ_REQ);
   assign vector    = 16'((16'(irq_idx) + 16'h0001) * VEC_WORDS);
   assign irq_hit   = s.flags[FL_I] && (|IRQ_REQ);
   assign run_ok    = (s.phase == PH_RUN) && s.fetch_ok;
   assign take_irq  = run_ok && irq_hit;

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb begin
      n          = s;
      n.dbus.we  = 1'b0;
      n.dbus.re  = 1'b0;
      n.irq_ack  = '0;
      acc_go     = 1'b0;
      acc_wr     = 1'b0;
      acc_addr   = '0;
      case (s.phase)
         PH_RUN: begin
            n.program_counter = s.program_counter + 16'h0001;
            n.fetch_ok = 1'b1;
            if (!s.fetch_ok) begin
               n.fetch_ok = 1'b1;
            end else if (take_irq) begin
               n.flags[FL_I] = 1'b0;
               n.irq_ack[irq_idx] = 1'b1;
               n.target = vector;
               n.spare = 8'(s.program_counter - 16'h0001 >> 8);
               n.dbus = '{s.stack_top_pointer,
                          8'(s.program_counter - 16'h0001), 1'b1, 1'b0};
               n.stack_top_pointer = s.stack_top_pointer - 16'h0001;
               n.program_counter = s.program_counter;
               n.fetch_ok = 1'b0;
               n.phase = PH_PUSH2;
            end else begin
               case (cur.kind)
                  OP_ADD, OP_ADD_CARRY, OP_SUB, OP_AND, OP_OR,
                  OP_XOR: begin
                     n.gpr[cur.rd] = alu_out[15:8];
                     n.flags = alu_out[7:0];
                  end
                  OP_COPY: n.gpr[cur.rd] = rr_val;
                  OP_LOAD_IMM: n.gpr[cur.rd] = cur.imm;
                  OP_BIT_STORE: n.flags[FL_T] = rd_val[cur.bsel];
                  OP_BIT_LOAD: n.gpr[cur.rd][cur.bsel] = s.flags[FL_T];
                  OP_IRQ_GATE_SET: n.flags[FL_I] = 1'b1;
                  OP_IRQ_GATE_CLEAR: n.flags[FL_I] = 1'b0;
                  OP_RETURN_FROM_IRQ: begin
                     n.dbus.re = 1'b1;
                     n.dbus.addr = s.stack_top_pointer + 16'h0001;
                     n.stack_top_pointer = n.dbus.addr;
                     n.program_counter = s.program_counter;
                     n.fetch_ok = 1'b0;
                     n.phase = PH_POP1;
                  end
                  OP_CALL, OP_LOAD_DIRECT, OP_STORE_DIRECT: begin
                     n.held = cur;
                     n.phase = PH_OPERAND;
                  end
                  OP_LOAD_PTR, OP_STORE_PTR: begin
                     acc_go = 1'b1;
                     acc_wr = (cur.kind == OP_STORE_PTR);
                     acc_addr = ptr_val;
                  end
                  OP_IO_READ, OP_IO_WRITE: begin
                     acc_go = 1'b1;
                     acc_wr = (cur.kind == OP_IO_WRITE);
                     acc_addr = io_addr;
                  end
                  OP_TABLE_READ: begin
                     n.held = cur;
                     n.program_counter = s.program_counter;
                     n.fetch_ok = 1'b0;
                     n.phase = PH_TABLE1;
                  end
                  default: n.gpr = s.gpr;
               endcase
            end
         end
         PH_OPERAND: begin
            n.phase = PH_RUN;
            n.program_counter = s.program_counter + 16'h0001;
            n.fetch_ok = 1'b1;
            case (s.held.kind)
               OP_CALL: begin
                  n.target = PM_WORD;
                  n.spare = s.program_counter[15:8];
                  n.dbus = '{s.stack_top_pointer,
                             s.program_counter[7:0], 1'b1, 1'b0};
                  n.stack_top_pointer = s.stack_top_pointer - 16'h0001;
                  n.program_counter = s.program_counter;
                  n.fetch_ok = 1'b0;
                  n.phase = PH_PUSH2;
               end
               OP_LOAD_DIRECT, OP_STORE_DIRECT: begin
                  acc_go = 1'b1;
                  acc_wr = (s.held.kind == OP_STORE_DIRECT);
                  acc_addr = PM_WORD;
               end
               default: n.phase = PH_RUN;
            endcase
         end
         PH_PUSH2: begin
            n.dbus = '{s.stack_top_pointer, s.spare, 1'b1, 1'b0};
            n.stack_top_pointer = s.stack_top_pointer - 16'h0001;
            n.program_counter = s.target;
            n.phase = PH_RUN;
         end
         PH_POP1: begin
            n.dbus.re = 1'b1;
            n.dbus.addr = s.stack_top_pointer + 16'h0001;
            n.stack_top_pointer = n.dbus.addr;
            n.phase = PH_POP2;
         end
         PH_POP2: begin
            n.spare = DM_RDATA;
            n.phase = PH_POP3;
         end
         PH_POP3: begin
            n.program_counter = {s.spare, DM_RDATA};
            n.flags[FL_I] = 1'b1;
            n.phase = PH_RUN;
         end
         PH_LOAD1, PH_TABLE1: begin
            n.phase = (s.phase == PH_LOAD1) ? PH_LOAD2 : PH_TABLE2;
         end
         PH_LOAD2, PH_TABLE2: begin
            n.gpr[s.held.rd] = (s.phase == PH_LOAD2) ? DM_RDATA :
                               table_ptr[0] ? PM_WORD[15:8] : PM_WORD[7:0];
            n.program_counter = s.program_counter + 16'h0001;
            n.fetch_ok = 1'b1;
            n.phase = PH_RUN;
         end
         default: n.phase = PH_RUN;
      endcase
      // Registers and flags answer inside the slice; the rest goes out.
      if (acc_go) begin
         case (region_of(acc_addr))
            RG_GPR: begin
               if (acc_wr) begin
                  n.gpr[acc_addr[4:0]] = rd_val;
               end else begin
                  n.gpr[cur.rd] = s.gpr[acc_addr[4:0]];
               end
            end
            RG_FLAGS: begin
               if (acc_wr) begin
                  n.flags = rd_val;
               end else begin
                  n.gpr[cur.rd] = s.flags;
               end
            end
            default: begin
               n.dbus = '{acc_addr, rd_val, acc_wr, !acc_wr};
               if (!acc_wr) begin
                  n.held = cur;
                  n.program_counter = s.program_counter;
                  n.fetch_ok = 1'b0;
                  n.phase = PH_LOAD1;
               end
            end
         endcase
      end
      n.pm_addr = (n.phase == PH_TABLE1) ? {1'b0, table_ptr[15:1]} :
                  n.program_counter;
   end

   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         s <= '0;
         s.flags <= FLAGS_RESET;
         s.stack_top_pointer <= STACK_RESET;
         s.program_counter <= RESET_VECTOR;
         s.pm_addr <= RESET_VECTOR;
      end else begin
         s <= n;
      end
   end

   assign PM_ADDR  = s.pm_addr;
   assign DM_ADDR  = s.dbus.addr;
   assign DM_WDATA = s.dbus.wdata;
   assign DM_WE    = s.dbus.we;
   assign DM_RE    = s.dbus.re;
   assign IRQ_ACK  = s.irq_ack;
   assign FLAGS    = s.flags;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);

   chk_sign_flag: assert property (
      run_ok && !irq_hit && is_alu |=>
         s.flags[FL_S] == (s.flags[FL_N] ^ s.flags[FL_V]))
      else $error("sign flag differs from negative xor overflow");
   chk_gate_blocks: assert property (
      run_ok && !s.flags[FL_I] |=> s.irq_ack == '0)
      else $error("interrupt taken while gate bit clear");
   chk_gate_cleared: assert property (
      (|s.irq_ack) |-> !s.flags[FL_I] && s.phase == PH_PUSH2)
      else $error("gate bit not cleared on interrupt entry");
   chk_lowest_first: assert property (
      (|s.irq_ack) |-> ((s.irq_ack - 1'b1) & $past(IRQ_REQ)) == '0)
      else $error("lower pending interrupt was skipped");
   chk_fetch_overlap: assert property (
      run_ok && !irq_hit && is_alu |=> s.fetch_ok && s.phase == PH_RUN
         && s.program_counter == $past(s.program_counter) + 16'h0001)
      else $error("fetch did not advance after single-cycle op");
   chk_push_return: assert property (
      take_irq |=> s.dbus.we ##1 s.dbus.we && !s.fetch_ok
         && s.program_counter == s.target)
      else $error("return address not pushed before vector jump");
   chk_return_gate: assert property (
      run_ok && !irq_hit && cur.kind == OP_RETURN_FROM_IRQ |=>
         !s.fetch_ok [*3] ##1 s.flags[FL_I] && s.phase == PH_RUN)
      else $error("return did not restore gate in four cycles");
   chk_flags_write: assert property (
      run_ok && !irq_hit && cur.kind == OP_IO_WRITE
         && cur.imm[5:0] == FLAGS_IO_ADDR |=> s.flags == $past(rd_val))
      else $error("flag write did not replace all bits");
   chk_io_offset: assert property (
      run_ok && !irq_hit && cur.kind == OP_IO_WRITE
         && cur.imm[5:0] != FLAGS_IO_ADDR |=>
         DM_WE && DM_ADDR == $past(io_addr) && DM_ADDR <= IO_DATA_LAST)
      else $error("I/O write landed off its data address");

endmodule
`default_nettype wire

// *** testbench/ccsf_mem_model.sv ***
// Program and data memory partner of the execution slice.
`timescale 1ns/100ps
`default_nettype none
module ccsf_mem_model import ccsf_pkg::*; (
   input  wire logic               REF_CLK,   // Core clock
   input  wire logic [15:0]        PM_ADDR,   // Fetch address
   output var  logic [15:0]        PM_WORD,   // Raw word
   output var  ccsf_pkg::ccsf_op_t OP,        // Decoded word
   input  wire logic [15:0]        DM_ADDR,   // Data address
   input  wire logic [7:0]         DM_WDATA,  // Store data
   input  wire logic               DM_WE,     // Store strobe
   input  wire logic               DM_RE,     // Load strobe
   output var  logic [7:0]         DM_RDATA   // Load data
);
   ccsf_op_t    prog  [0:63];
   logic [15:0] words [0:63];
   logic [7:0]  ram   [0:255];
   logic [5:0]  fetch_q;
   logic [7:0]  rd_addr_q;
   logic [7:0]  churn_q = 8'h00;
   logic        rd_ok_q;
   // Sync ROM: the word for an address shows one cycle later.
   always @(posedge REF_CLK) begin
      fetch_q <= PM_ADDR[5:0];
      rd_ok_q <= DM_RE;
      rd_addr_q <= DM_ADDR[7:0];
      churn_q <= churn_q + 8'h5B;
      if (DM_WE) begin
         ram[DM_ADDR[7:0]] <= DM_WDATA;
      end
   end
   assign PM_WORD = words[fetch_q];
   assign OP = prog[fetch_q];
   // Load data holds for one cycle only; a late sample sees churn.
   assign DM_RDATA = rd_ok_q ? ram[rd_addr_q] : churn_q;
endmodule
`default_nettype wire

// *** testbench/ccsf_core_bench.sv ***
// Self-checking bench of the execution slice.
`timescale 1ns/100ps
`default_nettype none
module ccsf_core_bench;
   import ccsf_pkg::*;
   localparam logic [15:0] SP0 = 16'h00FF;
   logic        REF_CLK, NRST, DM_WE, DM_RE;
   logic [15:0] PM_ADDR, PM_WORD, DM_ADDR, IRQ_REQ, IRQ_ACK;
   logic [7:0]  DM_WDATA, DM_RDATA, FLAGS, a, b;
   ccsf_op_t    OP;
   ccsf_kind_t  kinds [0:2] = '{OP_ADD, OP_SUB, OP_AND};
   int          failures, total_checks, t;
   logic [31:0] seed;
   logic [24:0] note;
   logic [24:0] note_q [$];
   ccsf_core #(.STACK_RESET(SP0)) ccsf_core_inst (.REF_CLK(REF_CLK),
      .NRST(NRST), .PM_ADDR(PM_ADDR), .PM_WORD(PM_WORD), .OP(OP),
      .DM_ADDR(DM_ADDR), .DM_WDATA(DM_WDATA), .DM_WE(DM_WE),
      .DM_RE(DM_RE), .DM_RDATA(DM_RDATA), .IRQ_REQ(IRQ_REQ),
      .IRQ_ACK(IRQ_ACK), .FLAGS(FLAGS));
   ccsf_mem_model ccsf_mem_model_inst (.REF_CLK(REF_CLK),
      .PM_ADDR(PM_ADDR), .PM_WORD(PM_WORD), .OP(OP), .DM_ADDR(DM_ADDR),
      .DM_WDATA(DM_WDATA), .DM_WE(DM_WE), .DM_RE(DM_RE),
      .DM_RDATA(DM_RDATA));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic put(int ad, ccsf_kind_t k, logic [4:0] d,
                      logic [7:0] i, logic [2:0] bs);
      ccsf_mem_model_inst.prog[ad] = '{k, d, 5'h11, i, bs, 2'h0};
      ccsf_mem_model_inst.words[ad] = {8'h00, i};
   endtask
   task automatic clear;
      for (int i = 0; i < 64; i++)
         put(i, OP_NOP, 5'h00, 8'h00, 3'h0);
   endtask
   task automatic rst;
      @(posedge REF_CLK);
      NRST <= 1'b0;
      repeat (4) @(posedge REF_CLK);
      NRST <= 1'b1;
      @(negedge REF_CLK);
   endtask
   // Waits until the op at address n has executed and settled.
   task automatic go(int n);
      t = 0;
      while (PM_ADDR !== 16'(n + 2) && t < 100) begin
         @(negedge REF_CLK);
         t++;
      end
      if (t == 100) failures++;
      repeat (2) @(negedge REF_CLK);
   endtask
   task automatic wait_ack;
      do begin
         @(negedge REF_CLK);
         t++;
      end while (IRQ_ACK === 16'h0000 && t < 60);
   endtask
   function automatic logic [7:0] alu_fl(int k, logic [7:0] x,
                                         logic [7:0] y);
      logic [8:0] r;
      logic       h, v;
      r = (k == 1) ? {1'b0, x} - y : {1'b0, x} + y;
      h = (k == 1) ? x[3:0] < y[3:0] : ({1'b0, x[3:0]} + y[3:0]) > 5'h0F;
      v = (x[7] ^ y[7] ^ (k != 1)) && r[7] != x[7];
      if (k == 2) begin
         r = {1'b0, x & y};
         h = 1'b0;
         v = 1'b0;
      end
      return {2'b00, h, r[7] ^ v, v, r[7], r[7:0] == 8'h00, r[8]};
   endfunction
   // ****************************************************************
   // Store watcher and stimulus
   // ****************************************************************
   // Stores are looked at mid-cycle, where the registered strobe has settled.
   always @(negedge REF_CLK) begin
      if (NRST === 1'b1 && DM_WE === 1'b1) begin
         note = (note_q.size() > 0) ? note_q.pop_front() : 25'h1FFFFFF;
         chk("store addr", note[23:8], DM_ADDR);
         if (note[24])
            chk("store data", {8'h00, note[7:0]}, {8'h00, DM_WDATA});
      end
   end
   initial begin
      REF_CLK = 1'b0;
      forever #2.5 REF_CLK = ~REF_CLK;
   end
   initial begin
      #300000;
      failures++;
      wrap_up;
   end
   initial begin
      seed = 32'hadd3c59f;
      NRST = 1'b0;
      IRQ_REQ = 16'h0000;
      failures = 0;
      total_checks = 0;
      clear;
      rst;
      chk("reset flags", {8'h00, FLAGS_RESET}, {8'h00, FLAGS});
      for (int i = 0; i < 12; i++) begin
         a = 8'($random(seed));
         b = (i == 4) ? a : 8'($random(seed));
         put(0, OP_LOAD_IMM, 5'h10, a, 3'h0);
         put(1, OP_LOAD_IMM, 5'h11, b, 3'h0);
         put(2, kinds[i % 3], 5'h10, 8'h00, 3'h0);
         rst;
         go(2);
         chk("alu flags", {8'h00, alu_fl(i % 3, a, b)}, {8'h00, FLAGS});
      end
      clear;
      put(0, OP_LOAD_IMM, 5'h01, 8'h40, 3'h0);
      put(1, OP_BIT_STORE, 5'h01, 8'h00, 3'h6);
      put(2, OP_IRQ_GATE_SET, 5'h00, 8'h00, 3'h0);
      rst;
      go(2);
      chk("gate set", 16'h00C0, {8'h00, FLAGS});
      put(3, OP_IRQ_GATE_CLEAR, 5'h00, 8'h00, 3'h0);
      rst;
      go(3);
      chk("gate clear", 16'h0040, {8'h00, FLAGS});
      clear;
      put(1, OP_CALL, 5'h00, 8'h00, 3'h0);
      put(2, OP_NOP, 5'h00, 8'h20, 3'h0);
      put(3, OP_IRQ_GATE_SET, 5'h00, 8'h00, 3'h0);
      note_q.push_back({1'b1, SP0, 8'h03});
      note_q.push_back({1'b1, SP0 - 16'h0001, 8'h00});
      rst;
      go(32);
      chk("call skips", 16'h0000, {8'h00, FLAGS});
      chk("call pushes", 16'h0000, 16'(note_q.size()));
      clear;
      put(0, OP_LOAD_IMM, 5'h10, 8'h5A, 3'h0);
      put(1, OP_IO_WRITE, 5'h10, 8'h05, 3'h0);
      put(2, OP_STORE_DIRECT, 5'h10, 8'h00, 3'h0);
      put(3, OP_NOP, 5'h00, 8'h60, 3'h0);
      put(4, OP_LOAD_DIRECT, 5'h12, 8'h00, 3'h0);
      put(5, OP_NOP, 5'h00, 8'h25, 3'h0);
      put(6, OP_IO_WRITE, 5'h12, 8'h3F, 3'h0);
      put(7, OP_IO_READ, 5'h13, 8'h3F, 3'h0);
      put(8, OP_LOAD_IMM, 5'h1A, 8'h61, 3'h0);
      put(9, OP_STORE_PTR, 5'h13, 8'h00, 3'h0);
      put(10, OP_LOAD_IMM, 5'h1E, 8'h28, 3'h0);
      put(11, OP_TABLE_READ, 5'h14, 8'h00, 3'h0);
      put(12, OP_STORE_PTR, 5'h14, 8'h00, 3'h0);
      put(20, OP_NOP, 5'h00, 8'hC3, 3'h0);
      note_q.push_back({1'b1, 16'h0025, 8'h5A});
      note_q.push_back({1'b1, 16'h0060, 8'h5A});
      note_q.push_back({1'b1, 16'h0061, 8'h5A});
      note_q.push_back({1'b1, 16'h0061, 8'hC3});
      rst;
      go(12);
      chk("flags write", 16'h005A, {8'h00, FLAGS});
      chk("data stores", 16'h0000, 16'(note_q.size()));
      clear;
      put(3, OP_IRQ_GATE_SET, 5'h00, 8'h00, 3'h0);
      put(4, OP_RETURN_FROM_IRQ, 5'h00, 8'h00, 3'h0);
      repeat (2) begin
         note_q.push_back({1'b1, SP0, 8'h04});
         note_q.push_back({1'b1, SP0 - 16'h0001, 8'h00});
      end
      @(posedge REF_CLK);
      IRQ_REQ <= 16'h0028;
      rst;
      t = 0;
      wait_ack;
      chk("gate held", 16'h0001, {15'h0, t >= 3});
      chk("first ack", 16'h0008, IRQ_ACK);
      chk("gate taken", 16'h0000, {15'h0, FLAGS[FL_I]});
      @(posedge REF_CLK);
      IRQ_REQ <= 16'h0020;
      t = 0;
      wait_ack;
      chk("second ack", 16'h0020, IRQ_ACK);
      repeat (4) @(negedge REF_CLK);
      // Interrupt entry stacks only the return address; the flags are never pushed.
      chk("irq pushes", 16'h0000, 16'(note_q.size()));
      wrap_up;
   end
endmodule
`default_nettype wire
